// [prfd_pkg.sv]
// Package: constants and carriers for the paged register file decoder
package prfd_pkg;

    // ----------------------------------------------------------------
    // Address space layout
    // ----------------------------------------------------------------
    localparam int unsigned REG_COUNT     = 256;
    localparam logic [3:0]  GRP_WORKONLY  = 4'hd;
    localparam logic [3:0]  GRP_SYSTEM    = 4'he;
    localparam logic [3:0]  GRP_PAGED     = 4'hf;
    localparam logic [4:0]  BLK_SYSTEM    = 5'h1c;
    localparam logic [4:0]  BLK_PAGED     = 5'h1e;
    localparam logic [4:0]  PTR_RST       = 5'h00;
    localparam logic [5:0]  PAGE_RST      = 6'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PRFD_OP_NONE = 2'b00,
        PRFD_OP_ABS  = 2'b01,
        PRFD_OP_WORK = 2'b10
    } prfd_mode_t;

    typedef enum logic [1:0] {
        PRFD_SET_NONE = 2'b00,
        PRFD_SET_PAIR = 2'b01,
        PRFD_SET_LOW  = 2'b10,
        PRFD_SET_HIGH = 2'b11
    } prfd_set_t;

    // Operand request from instruction decode
    typedef struct packed {
        prfd_mode_t mode;
        logic [7:0] abs_num;
        logic [3:0] work_idx;
        logic       pair;
        logic       bit_op;
    } prfd_req_t;

    // Decoded operand location
    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] addr;
        logic [7:0] addr_odd;
        logic       paged;
        logic [5:0] page;
        logic       system;
    } prfd_dec_t;

endpackage : prfd_pkg

// [prfd_decoder.sv]
// Operand address decoder with block pointers and peripheral paging
//
// Contract
// - 256 byte registers, 8-bit absolute number
// - Group 13 not reachable by absolute number
// - Pair access uses even register, next odd
// - Working access uses 4-bit index
// - Absolute number is group concat index
// - Index k in group g gives 16g+k
// - Groups 14 system, 15 peripheral
// - Group 15 routed to page pointer's pack
// - Page pointer selects one of 64 pages
// - Pointers hold 5-bit block numbers 0-31
// - Arguments 2n and 2n+1 select group n
// - Pointer pair of two directly writable registers
// - Bit instructions take working operands only
// - Pointers may select blocks 28 and 30
// - Pointer change leaves register contents untouched
// - Split mode: 0-7 low block, 8-15 high
`timescale 1ns/1ps

module prfd_decoder (
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire prfd_pkg::prfd_set_t set_op,
    input  wire logic [4:0]         set_arg,
    input  wire logic               page_wr,
    input  wire logic [5:0]         page_arg,
    input  wire logic               split_mode,
    input  wire prfd_pkg::prfd_req_t req,
    output prfd_pkg::prfd_dec_t      dec,
    output logic [4:0]              low_block_pointer,
    output logic [4:0]              high_block_pointer,
    output logic [5:0]              peripheral_page_select
);

    // ----------------------------------------------------------------
    // Pointer state
    // ----------------------------------------------------------------
    logic [4:0] low_r;
    logic [4:0] low_nxt;
    logic [4:0] high_r;
    logic [4:0] high_nxt;
    logic [5:0] page_r;
    logic [5:0] page_nxt;

    // Pair set forces the high pointer to the odd block of the same group
    wire logic [4:0] grp_even = {set_arg[4:1], 1'b0};
    wire logic [4:0] grp_odd  = {set_arg[4:1], 1'b1};

    // Any block 0-31 is accepted, including 28 and 30
    assign low_nxt  = (set_op == prfd_pkg::PRFD_SET_PAIR) ? grp_even :
                      (set_op == prfd_pkg::PRFD_SET_LOW)  ? set_arg  : low_r;
    assign high_nxt = (set_op == prfd_pkg::PRFD_SET_PAIR) ? grp_odd  :
                      (set_op == prfd_pkg::PRFD_SET_HIGH) ? set_arg  : high_r;
    assign page_nxt = page_wr ? page_arg : page_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            low_r  <= prfd_pkg::PTR_RST;
            high_r <= prfd_pkg::PTR_RST;
            page_r <= prfd_pkg::PAGE_RST;
        end else begin
            low_r  <= low_nxt;
            high_r <= high_nxt;
            page_r <= page_nxt;
        end
    end

    assign low_block_pointer      = low_r;
    assign high_block_pointer     = high_r;
    assign peripheral_page_select = page_r;

    // ----------------------------------------------------------------
    // Operand decode (registered, uses block pointers as held before this edge, page as written at it)
    // ----------------------------------------------------------------
    // Working address: unified mode concatenates group and index
    wire logic [7:0] work_unified = {low_r[4:1], req.work_idx};
    wire logic [4:0] split_blk    = req.work_idx[3] ? high_r : low_r;
    wire logic [7:0] work_split   = {split_blk, req.work_idx[2:0]};
    wire logic [7:0] work_addr    = split_mode ? work_split : work_unified;

    wire logic is_abs   = (req.mode == prfd_pkg::PRFD_OP_ABS);
    wire logic is_work  = (req.mode == prfd_pkg::PRFD_OP_WORK);
    wire logic [7:0] raw_addr = is_abs ? req.abs_num : work_addr;

    wire logic abs_bad  = is_abs &&
                          (req.abs_num[7:4] == prfd_pkg::GRP_WORKONLY ||
                           req.bit_op);
    wire logic pair_bad = req.pair && raw_addr[0];
    wire logic any_op   = is_abs || is_work;
    wire logic bad      = any_op && (abs_bad || pair_bad);

    wire logic [7:0] odd_addr = {raw_addr[7:1], 1'b1};
    wire logic hit_paged = raw_addr[7:4] == prfd_pkg::GRP_PAGED;
    wire logic hit_sys   = raw_addr[7:4] == prfd_pkg::GRP_SYSTEM;

    prfd_pkg::prfd_dec_t dec_nxt;
    always_comb begin
        dec_nxt          = '0;
        dec_nxt.valid    = any_op && !bad;
        dec_nxt.err      = bad;
        dec_nxt.addr     = raw_addr;
        dec_nxt.addr_odd = odd_addr;
        dec_nxt.paged    = any_op && !bad && hit_paged;
        // Page taken from the pointer that will be live this cycle
        dec_nxt.page     = page_nxt;
        dec_nxt.system   = any_op && !bad && hit_sys;
    end

    // Decode sees the current block pointers but a page written this cycle; a block set in the same cycle is for
    // the following instruction, so no stall is ever needed
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dec <= '0;
        end else begin
            dec <= dec_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_pair_set;
        @(posedge mclk) disable iff (!reset_n)
        set_op == prfd_pkg::PRFD_SET_PAIR |=>
            low_r == {$past(set_arg[4:1]), 1'b0} && high_r == {$past(set_arg[4:1]), 1'b1};
    endproperty
    a_pair_set: assert property (p_pair_set) else $error("pair set wrong");

    property p_next_decode;
        @(posedge mclk) disable iff (!reset_n)
        (set_op == prfd_pkg::PRFD_SET_PAIR) ##1 (is_work && !split_mode && !req.pair) |=>
            dec.addr == {$past(set_arg[4:1], 2), $past(req.work_idx)};
    endproperty
    a_next_decode: assert property (p_next_decode) else $error("pointer not live");

    property p_group13;
        @(posedge mclk) disable iff (!reset_n)
        is_abs && req.abs_num[7:4] == 4'hd |=> dec.err && !dec.valid;
    endproperty
    a_group13: assert property (p_group13) else $error("group 13 absolute");

    property p_bitop;
        @(posedge mclk) disable iff (!reset_n)
        is_abs && req.bit_op |=> !dec.valid;
    endproperty
    a_bitop: assert property (p_bitop) else $error("bit op absolute");

    property p_pair_odd;
        @(posedge mclk) disable iff (!reset_n)
        (is_abs || is_work) && req.pair |=>
            dec.err || (!dec.addr[0] && dec.addr_odd == dec.addr + 8'h01);
    endproperty
    a_pair_odd: assert property (p_pair_odd) else $error("pair partner");

    property p_split;
        @(posedge mclk) disable iff (!reset_n)
        is_work && split_mode && req.work_idx[3] && !req.pair |=>
            dec.addr[7:3] == $past(high_r) && dec.addr[2:0] == $past(req.work_idx[2:0]);
    endproperty
    a_split: assert property (p_split) else $error("split high block");

    property p_paged;
        @(posedge mclk) disable iff (!reset_n)
        dec.valid && dec.addr[7:4] == 4'hf |-> dec.paged && dec.page == page_r;
    endproperty
    a_paged: assert property (p_paged) else $error("paged routing");

    property p_hold;
        @(posedge mclk) disable iff (!reset_n)
        set_op == prfd_pkg::PRFD_SET_NONE && !page_wr |=>
            $stable(low_r) && $stable(high_r) && $stable(page_r);
    endproperty
    a_hold: assert property (p_hold) else $error("pointer drift");

    property p_abs_pass;
        @(posedge mclk) disable iff (!reset_n)
        is_abs && !req.bit_op && !req.pair && req.abs_num[7:4] != prfd_pkg::GRP_WORKONLY |=>
            dec.valid && dec.addr == $past(req.abs_num);
    endproperty
    a_abs_pass: assert property (p_abs_pass) else $error("absolute number lost");

    property p_unified;
        @(posedge mclk) disable iff (!reset_n)
        is_work && !split_mode && !req.pair |=>
            dec.valid && dec.addr == {$past(low_r[4:1]), $past(req.work_idx)};
    endproperty
    a_unified: assert property (p_unified) else $error("group and index");

    property p_split_low;
        @(posedge mclk) disable iff (!reset_n)
        is_work && split_mode && !req.work_idx[3] && !req.pair |=>
            dec.addr[7:3] == $past(low_r) && dec.addr[2:0] == $past(req.work_idx[2:0]);
    endproperty
    a_split_low: assert property (p_split_low) else $error("split low block");

    property p_system;
        @(posedge mclk) disable iff (!reset_n)
        dec.valid |-> dec.system == (dec.addr[7:4] == prfd_pkg::GRP_SYSTEM) &&
            dec.paged == (dec.addr[7:4] == prfd_pkg::GRP_PAGED);
    endproperty
    a_system: assert property (p_system) else $error("group flags");

    property p_idle;
        @(posedge mclk) disable iff (!reset_n)
        req.mode == prfd_pkg::PRFD_OP_NONE |=> !dec.valid && !dec.err && !dec.paged;
    endproperty
    a_idle: assert property (p_idle) else $error("decode without request");

    property p_one_answer;
        @(posedge mclk) disable iff (!reset_n)
        !(dec.valid && dec.err);
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("valid and error");

    property p_page_load;
        @(posedge mclk) disable iff (!reset_n)
        page_wr |=> page_r == $past(page_arg);
    endproperty
    a_page_load: assert property (p_page_load) else $error("page not loaded");

    property p_low_set;
        @(posedge mclk) disable iff (!reset_n)
        set_op == prfd_pkg::PRFD_SET_LOW |=> low_r == $past(set_arg) && $stable(high_r);
    endproperty
    a_low_set: assert property (p_low_set) else $error("low pointer set");

    property p_high_set;
        @(posedge mclk) disable iff (!reset_n)
        set_op == prfd_pkg::PRFD_SET_HIGH |=> high_r == $past(set_arg) && $stable(low_r);
    endproperty
    a_high_set: assert property (p_high_set) else $error("high pointer set");

endmodule : prfd_decoder

// [prfd_core_model.sv]
// Instruction decode side model driving pointer sets and operand requests
`timescale 1ns/1ps

module prfd_core_model (
    output prfd_pkg::prfd_set_t set_op,
    output logic [4:0]          set_arg,
    output logic                page_wr,
    output logic [5:0]          page_arg,
    output logic                split_mode,
    output prfd_pkg::prfd_req_t req,
    input  wire logic           mclk
);
    // One instruction per cycle, launched on the falling edge
    task automatic cyc(input prfd_pkg::prfd_set_t op, input logic [4:0] a, input logic pw,
                       input logic [5:0] pa, input prfd_pkg::prfd_req_t r);
        @(negedge mclk);
        set_op   = op;
        set_arg  = a;
        page_wr  = pw;
        page_arg = pa;
        req      = r;
    endtask : cyc

    // Unused operand lines flip so a stale value never passes for a live one
    task automatic idle();
        cyc(prfd_pkg::PRFD_SET_NONE, ~set_arg, 1'b0, ~page_arg,
            '{prfd_pkg::PRFD_OP_NONE, ~req.abs_num, ~req.work_idx, 1'b0, 1'b0});
    endtask : idle

    initial begin
        set_op     = prfd_pkg::PRFD_SET_NONE;
        set_arg    = 5'h00;
        page_wr    = 1'b0;
        page_arg   = 6'h00;
        split_mode = 1'b0;
        req        = '{prfd_pkg::PRFD_OP_NONE, 8'h00, 4'h0, 1'b0, 1'b0};
    end
endmodule : prfd_core_model

// [paged_register_file_decoder_tb.sv]
// Self-checking testbench for the paged register file decoder
`timescale 1ns/1ps

module paged_register_file_decoder_tb;
    logic                mclk = 1'b0;
    logic                reset_n = 1'b0;
    prfd_pkg::prfd_set_t set_op;
    logic [4:0]          set_arg, low_p, high_p;
    logic                page_wr, split_mode;
    logic [5:0]          page_arg, page_p;
    prfd_pkg::prfd_req_t req;
    prfd_pkg::prfd_dec_t dec;
    int                  bad_count = 0;
    int                  cmp_count = 0;

    always #4 mclk = ~mclk;

    prfd_core_model u_core (.mclk(mclk), .set_op(set_op), .set_arg(set_arg), .page_wr(page_wr),
        .page_arg(page_arg), .split_mode(split_mode), .req(req));
    prfd_decoder u_dut (.mclk(mclk), .reset_n(reset_n), .set_op(set_op), .set_arg(set_arg),
        .page_wr(page_wr), .page_arg(page_arg), .split_mode(split_mode), .req(req), .dec(dec),
        .low_block_pointer(low_p), .high_block_pointer(high_p), .peripheral_page_select(page_p));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Request taken at one edge, result read at the next falling edge
    task automatic rq(input prfd_pkg::prfd_mode_t m, input logic [7:0] n, input logic [3:0] k,
                      input logic pr, input logic bo, input logic [7:0] ea, input logic ee);
        u_core.cyc(prfd_pkg::PRFD_SET_NONE, 5'h00, 1'b0, 6'h00, '{m, n, k, pr, bo});
        u_core.idle();
        chk({dec.valid, dec.err, ee ? 8'h00 : dec.addr}, {~ee, ee, ee ? 8'h00 : ea});
    endtask : rq

    task automatic t_pair();
        chk({low_p, high_p, page_p}, 16'h0000);
        chk(32'(dec), 32'h0);
        u_core.cyc(prfd_pkg::PRFD_SET_PAIR, 5'h03, 1'b0, 6'h00, req);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h3, 1'b0, 1'b0, 8'h13, 1'b0);
        chk({low_p, high_p}, {5'h02, 5'h03});
        u_core.cyc(prfd_pkg::PRFD_SET_PAIR, 5'h05, 1'b0, 6'h00, req);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h0, 1'b0, 1'b0, 8'h20, 1'b0);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h3, 1'b1, 1'b0, 8'h00, 1'b1);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h2, 1'b1, 1'b0, 8'h22, 1'b0);
        chk(dec.addr_odd, 8'h23);
    endtask : t_pair

    task automatic t_groups();
        for (int g = 0; g < 16; g++) begin
            u_core.cyc(prfd_pkg::PRFD_SET_PAIR, 5'(2 * g), 1'b0, 6'h00, req);
            rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'(g) ^ 4'h5, 1'b0, 1'b1,
               {4'(g), 4'(g) ^ 4'h5}, 1'b0);
            chk({dec.paged, dec.system}, {g == 15, g == 14});
        end
    endtask : t_groups

    // High block read right after its set, so the new pointer must be live
    task automatic t_split();
        u_core.split_mode = 1'b1;
        u_core.cyc(prfd_pkg::PRFD_SET_LOW, 5'h02, 1'b0, 6'h00, req);
        u_core.cyc(prfd_pkg::PRFD_SET_HIGH, 5'h1b, 1'b0, 6'h00, req);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h8, 1'b0, 1'b0, 8'hd8, 1'b0);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h0, 1'b0, 1'b0, 8'h10, 1'b0);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h7, 1'b0, 1'b0, 8'h17, 1'b0);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'hf, 1'b0, 1'b0, 8'hdf, 1'b0);
        chk({low_p, high_p}, {5'h02, 5'h1b});
        u_core.split_mode = 1'b0;
    endtask : t_split

    task automatic t_abs();
        rq(prfd_pkg::PRFD_OP_ABS, 8'h49, 4'h0, 1'b0, 1'b0, 8'h49, 1'b0);
        rq(prfd_pkg::PRFD_OP_ABS, 8'hd0, 4'h0, 1'b0, 1'b0, 8'h00, 1'b1);
        rq(prfd_pkg::PRFD_OP_ABS, 8'hdf, 4'h0, 1'b0, 1'b0, 8'h00, 1'b1);
        rq(prfd_pkg::PRFD_OP_ABS, 8'h40, 4'h0, 1'b0, 1'b1, 8'h00, 1'b1);
        rq(prfd_pkg::PRFD_OP_ABS, 8'h3c, 4'h0, 1'b1, 1'b0, 8'h3c, 1'b0);
        chk(dec.addr_odd, 8'h3d);
        rq(prfd_pkg::PRFD_OP_ABS, 8'h3d, 4'h0, 1'b1, 1'b0, 8'h00, 1'b1);
        rq(prfd_pkg::PRFD_OP_ABS, 8'he5, 4'h0, 1'b0, 1'b0, 8'he5, 1'b0);
        chk({dec.system, dec.paged}, 2'b10);
    endtask : t_abs

    task automatic t_page();
        for (int p = 0; p < 64; p += 21) begin
            u_core.cyc(prfd_pkg::PRFD_SET_NONE, 5'h00, 1'b1, 6'(p), req);
            rq(prfd_pkg::PRFD_OP_ABS, 8'hf3, 4'h0, 1'b0, 1'b0, 8'hf3, 1'b0);
            chk({dec.paged, dec.page, page_p}, {1'b1, 6'(p), 6'(p)});
        end
    endtask : t_page

    // Mid-run reset must clear pointers left over from earlier scenarios
    task automatic t_reset();
        reset_n = 1'b0;
        u_core.idle();
        u_core.idle();
        reset_n = 1'b1;
        chk({low_p, high_p, page_p}, 16'h0000);
        chk(32'(dec), 32'h0);
        rq(prfd_pkg::PRFD_OP_WORK, 8'h00, 4'h5, 1'b0, 1'b0, 8'h05, 1'b0);
    endtask : t_reset

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        t_pair();
        t_groups();
        t_split();
        t_abs();
        t_page();
        t_reset();
        print_verdict();
    end

    // Whole run needs about 120 cycles
    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end
endmodule : paged_register_file_decoder_tb
